// *** rtl/zeroing_unit_regs.svh ***
/*
  Register addresses, reset values, unit codes and zeroing limits of the
  zeroing status and unit selection register bank.
  Assumes 16-bit register addressing; every 32-bit value spans two addresses.
*/
`ifndef ZEROING_UNIT_REGS_SVH
`define ZEROING_UNIT_REGS_SVH

// ----------------------------------------------------------------------------
// Register base addresses (even address holds the upper half)
// ----------------------------------------------------------------------------
`define ADDR_ZERO_TEMP_CORRECTION_FACTOR 16'h4700
`define ADDR_CURRENT_ZERO_OFFSET 16'h4702
`define ADDR_ZEROING_INTERIM_PHASE 16'h4704
`define ADDR_ZEROING_PROGRESS_COUNT 16'h4706
`define ADDR_PREVIOUS_ZERO_OFFSET 16'h4708
`define ADDR_TEMP_UNIT_SELECT 16'h6100
`define ADDR_PRESS_UNIT_SELECT 16'h6102
`define ADDR_WEIGHT_UNIT_SELECT 16'h6104
`define ADDR_WEIGHT_RATE_UNIT_SELECT 16'h6106

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_TEMP_UNIT_SELECT 32'h0000_03e9
`define RST_PRESS_UNIT_SELECT 32'h0000_0470
`define RST_WEIGHT_UNIT_SELECT 32'h0000_0440
`define RST_WEIGHT_RATE_UNIT_SELECT 32'h0000_052b

// ----------------------------------------------------------------------------
// Unit codes
// ----------------------------------------------------------------------------
`define UNIT_EXT_BASE 32'h0000_9c40
`define TEMP_KELVIN 32'h0000_03e8
`define TEMP_RANKINE 32'h0000_03eb
`define PRESS_PASCAL 32'h0000_046a
`define PRESS_KPA 32'h0000_046d
`define PRESS_HPA 32'h0000_0470
`define PRESS_BAR 32'h0000_0471
`define PRESS_MBAR 32'h0000_0472
`define PRESS_TORR 32'h0000_0473
`define PRESS_PSIA 32'h0000_0475
`define WEIGHT_KG 32'h0000_0440
`define WEIGHT_G 32'h0000_0441
`define WEIGHT_MG 32'h0000_0442
`define WEIGHT_TONNE 32'h0000_0444
`define WEIGHT_OUNCE 32'h0000_0445
`define WEIGHT_POUND 32'h0000_0446
`define WEIGHT_SHORT_TON 32'h0000_0447
`define WEIGHT_MT_EXT 32'h0000_9c41
`define RATE_STD_FIRST 32'h0000_0526
`define RATE_STD_LAST 32'h0000_0539
`define RATE_EXT_FIRST 32'h0000_a410
`define RATE_EXT_LAST 32'h0000_a412

// ----------------------------------------------------------------------------
// Zeroing sample count limits
// ----------------------------------------------------------------------------
`define ZERO_SAMPLES_MIN 11'h001
`define ZERO_SAMPLES_MAX 11'h400
`define ZERO_SAMPLES_DEF 11'h1f4

`endif

// *** rtl/zeroing_unit_pkg.sv ***
/*
  Types of the zeroing status and unit selection register bank.
  Assumes the constants header is included by the users of this package.
*/
package zeroing_unit_pkg;

  typedef enum logic [1:0] {
    ZS_IDLE = 2'b00,
    ZS_RUN = 2'b01,
    ZS_FINISH = 2'b11
  } zero_phase_e;

  typedef struct packed {
    zero_phase_e st;
    logic [10:0] progress;
    logic [31:0] interim;
    logic [31:0] cur_zero;
    logic [31:0] prev_zero;
    logic [31:0] final_phase;
    logic final_load;
    logic [3:0][31:0] units;
    logic [15:0] pend_hi;
    logic [15:0] rdata;
    logic rvalid;
    logic rerr;
  } bank_state_s;

endpackage

// *** rtl/zeroing_status_and_unit_select_regs.sv ***
/*
  Zeroing status registers and unit selection registers of a flow
  transmitter, reached through a 16-bit register port as a field master sees it.
  Assumes all inputs come from logic on clk, and that a fieldbus front end
  turns master requests into single-cycle read and write strobes.
*/
// Overview of operation
// - Temperature corrected zero factor, read only
// - Current zero point readable, 8 ns units
// - Interim phase shown while zeroing runs
// - Final phase moved to holding register
// - Progress register reads zero when done
// - Nonzero downcounter while running, decrements per sample
// - Prior zero point kept before replacement
// - Temperature codes 1000 to 1003 accepted
// - Temperature defaults to Celsius
// - Seven pressure codes accepted
// - Pressure defaults to hectopascal
// - Eight mass codes accepted
// - Mass defaults to kilogram
// - Mass flow codes 1318-1337, 42000-42002 accepted
// - Non-standard units coded above 40000
// - Sample count 1 to 1024, default 500
`timescale 1ns/100ps
`include "zeroing_unit_regs.svh"

module zeroing_status_and_unit_select_regs
  import zeroing_unit_pkg::*;
#(
  parameter logic [10:0] SAMPLES_MAX = `ZERO_SAMPLES_MAX,
  parameter logic [10:0] SAMPLES_DEF = `ZERO_SAMPLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_err,
  input wire logic [31:0] temp_factor_in,
  input wire logic [10:0] zeroing_sample_total,
  input wire logic zero_start,
  input wire logic sample_tick,
  input wire logic [31:0] phase_in,
  output logic zeroing_busy,
  output logic [31:0] zero_offset,
  output logic [31:0] final_phase,
  output logic final_phase_load,
  output logic [31:0] temp_unit_select,
  output logic [31:0] press_unit_select,
  output logic [31:0] weight_unit_select,
  output logic [31:0] weight_rate_unit_select
);

  // --------------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------------
  localparam logic [3:0] IDX_NONE = 4'hf;
  localparam logic [3:0] IDX_FIRST_UNIT = 4'h5;

  // Maps a register address to its slot; the low bit picks the half
  function automatic logic [3:0] reg_slot(input logic [15:0] addr);
    logic [15:0] base;
    base = {addr[15:1], 1'b0};
    unique case (base)
      `ADDR_ZERO_TEMP_CORRECTION_FACTOR: reg_slot = 4'h0;
      `ADDR_CURRENT_ZERO_OFFSET: reg_slot = 4'h1;
      `ADDR_ZEROING_INTERIM_PHASE: reg_slot = 4'h2;
      `ADDR_ZEROING_PROGRESS_COUNT: reg_slot = 4'h3;
      `ADDR_PREVIOUS_ZERO_OFFSET: reg_slot = 4'h4;
      `ADDR_TEMP_UNIT_SELECT: reg_slot = 4'h5;
      `ADDR_PRESS_UNIT_SELECT: reg_slot = 4'h6;
      `ADDR_WEIGHT_UNIT_SELECT: reg_slot = 4'h7;
      `ADDR_WEIGHT_RATE_UNIT_SELECT: reg_slot = 4'h8;
      default: reg_slot = IDX_NONE;
    endcase
  endfunction

  // Legal codes per unit register: 0 temp, 1 pressure, 2 mass, 3 mass flow
  function automatic logic unit_ok(input logic [1:0] sel, input logic [31:0] code);
    logic ext;
    ext = code > `UNIT_EXT_BASE;
    unique case (sel)
      2'h0: unit_ok = code >= `TEMP_KELVIN && code <= `TEMP_RANKINE;
      2'h1: unit_ok = code inside {`PRESS_PASCAL, `PRESS_KPA, `PRESS_HPA, `PRESS_BAR,
                                   `PRESS_MBAR, `PRESS_TORR, `PRESS_PSIA};
      2'h2: unit_ok = ext ? code == `WEIGHT_MT_EXT
                          : code inside {`WEIGHT_KG, `WEIGHT_G, `WEIGHT_MG, `WEIGHT_TONNE,
                                         `WEIGHT_OUNCE, `WEIGHT_POUND, `WEIGHT_SHORT_TON};
      2'h3: unit_ok = ext ? code >= `RATE_EXT_FIRST && code <= `RATE_EXT_LAST
                          : code >= `RATE_STD_FIRST && code <= `RATE_STD_LAST;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam bank_state_s RESET_S = '{
    st: ZS_IDLE,
    progress: 11'h000,
    interim: 32'h0000_0000,
    cur_zero: 32'h0000_0000,
    prev_zero: 32'h0000_0000,
    final_phase: 32'h0000_0000,
    final_load: 1'b0,
    units: {`RST_WEIGHT_RATE_UNIT_SELECT, `RST_WEIGHT_UNIT_SELECT,
            `RST_PRESS_UNIT_SELECT, `RST_TEMP_UNIT_SELECT},
    pend_hi: 16'h0000,
    rdata: 16'h0000,
    rvalid: 1'b0,
    rerr: 1'b0
  };

  bank_state_s s_r;
  bank_state_s s_nxt;
  logic [3:0] slot;
  logic [31:0] read_word;
  logic [31:0] wr_code;
  logic [1:0] unit_sel;
  logic [10:0] seed_cnt;
  logic unit_commit;

  assign slot = reg_slot(reg_addr);
  assign unit_sel = 2'(slot - IDX_FIRST_UNIT);
  assign wr_code = {s_r.pend_hi, reg_wdata};
  assign unit_commit = reg_wr && !reg_rd && slot >= IDX_FIRST_UNIT && slot != IDX_NONE && reg_addr[0];

  // Out-of-range totals fall back to the default rather than stall zeroing
  assign seed_cnt = (zeroing_sample_total < `ZERO_SAMPLES_MIN || zeroing_sample_total > SAMPLES_MAX)
                    ? SAMPLES_DEF : zeroing_sample_total;

  // --------------------------------------------------------------------------
  // Read word selection
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (slot)
      4'h0: read_word = temp_factor_in;
      4'h1: read_word = s_r.cur_zero;
      4'h2: read_word = s_r.interim;
      4'h3: read_word = {21'h0, s_r.progress};
      4'h4: read_word = s_r.prev_zero;
      4'h5, 4'h6, 4'h7, 4'h8: read_word = s_r.units[unit_sel];
      default: read_word = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.rerr = 1'b0;
    s_nxt.final_load = 1'b0;

    // Zeroing sequencer
    unique case (s_r.st)
      ZS_IDLE: begin
        if (zero_start) begin
          s_nxt.progress = seed_cnt;
          s_nxt.st = ZS_RUN;
        end
      end
      ZS_RUN: begin
        if (sample_tick) begin
          s_nxt.interim = phase_in;
          s_nxt.progress = 11'(s_r.progress - 11'h001);
          if (s_r.progress == 11'h001) begin
            s_nxt.st = ZS_FINISH;
          end
        end
      end
      ZS_FINISH: begin
        s_nxt.prev_zero = s_r.cur_zero;
        s_nxt.cur_zero = s_r.interim;
        s_nxt.final_phase = s_r.interim;
        s_nxt.final_load = 1'b1;
        s_nxt.st = ZS_IDLE;
      end
      default: s_nxt.st = ZS_IDLE;
    endcase

    // Register port; a read and a write in one cycle are both refused
    if (reg_rd && reg_wr) begin
      s_nxt.rerr = 1'b1;
    end else if (reg_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rerr = slot == IDX_NONE;
      s_nxt.rdata = reg_addr[0] ? read_word[15:0] : read_word[31:16];
    end else if (reg_wr) begin
      if (slot == IDX_NONE || slot < IDX_FIRST_UNIT) begin
        s_nxt.rerr = 1'b1;
      end else if (!reg_addr[0]) begin
        // Upper half waits for the lower half so no torn code is ever live
        s_nxt.pend_hi = reg_wdata;
      end else if (unit_ok(unit_sel, wr_code)) begin
        s_nxt.units[unit_sel] = wr_code;
      end else begin
        s_nxt.rerr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= RESET_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata = s_r.rdata;
  assign reg_rvalid = s_r.rvalid;
  assign reg_err = s_r.rerr;
  assign zeroing_busy = s_r.st != ZS_IDLE;
  assign zero_offset = s_r.cur_zero;
  assign final_phase = s_r.final_phase;
  assign final_phase_load = s_r.final_load;
  assign temp_unit_select = s_r.units[0];
  assign press_unit_select = s_r.units[1];
  assign weight_unit_select = s_r.units[2];
  assign weight_rate_unit_select = s_r.units[3];

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_progress_idle_zero:
    assert property (@(posedge clk) disable iff (reset) s_r.st == ZS_IDLE |-> s_r.progress == 11'h000)
    else $error("progress count not zero while idle");

  a_progress_run_nonzero:
    assert property (@(posedge clk) disable iff (reset) s_r.st == ZS_RUN |-> s_r.progress != 11'h000)
    else $error("progress count zero while zeroing runs");

  a_progress_step:
    assert property (@(posedge clk) disable iff (reset)
      s_r.st == ZS_RUN && sample_tick |=> s_r.progress == 11'($past(s_r.progress) - 11'h001))
    else $error("progress count did not step down by one");

  a_seed_count:
    assert property (@(posedge clk) disable iff (reset)
      s_r.st == ZS_IDLE && zero_start |=> s_r.st == ZS_RUN && s_r.progress == $past(seed_cnt)
        && s_r.progress >= `ZERO_SAMPLES_MIN && s_r.progress <= SAMPLES_MAX)
    else $error("zeroing did not start with the sample total");

  a_interim_track:
    assert property (@(posedge clk) disable iff (reset)
      s_r.st == ZS_RUN && sample_tick |=> s_r.interim == $past(phase_in))
    else $error("interim phase not taken from sample");

  a_final_transfer:
    assert property (@(posedge clk) disable iff (reset)
      s_r.st == ZS_RUN && sample_tick && s_r.progress == 11'h001
        |=> ##1 final_phase_load && final_phase == $past(s_r.interim) && !zeroing_busy)
    else $error("final phase not transferred at end of zeroing");

  a_prior_kept:
    assert property (@(posedge clk) disable iff (reset)
      s_r.st == ZS_FINISH |=> s_r.prev_zero == $past(s_r.cur_zero) && zero_offset == $past(s_r.interim))
    else $error("prior zero point not kept on replacement");

  a_unit_reject:
    assert property (@(posedge clk) disable iff (reset)
      unit_commit && !unit_ok(unit_sel, wr_code) |=> s_r.units == $past(s_r.units) && reg_err)
    else $error("illegal unit code was not rejected");

  a_unit_accept:
    assert property (@(posedge clk) disable iff (reset)
      unit_commit && unit_ok(unit_sel, wr_code) |=> s_r.units[$past(unit_sel)] == $past(wr_code) && !reg_err)
    else $error("legal unit code was not stored");

  a_units_legal:
    assert property (@(posedge clk) disable iff (reset)
      unit_ok(2'h0, temp_unit_select) && unit_ok(2'h1, press_unit_select)
        && unit_ok(2'h2, weight_unit_select) && unit_ok(2'h3, weight_rate_unit_select))
    else $error("a unit selection holds an illegal code");

  a_reset_defaults:
    assert property (@(posedge clk) $past(reset) |-> temp_unit_select == `RST_TEMP_UNIT_SELECT
      && press_unit_select == `RST_PRESS_UNIT_SELECT && weight_unit_select == `RST_WEIGHT_UNIT_SELECT
      && weight_rate_unit_select == `RST_WEIGHT_RATE_UNIT_SELECT)
    else $error("unit selections not at defaults after reset");

  a_read_factor:
    assert property (@(posedge clk) disable iff (reset)
      reg_rd && !reg_wr && reg_addr == `ADDR_ZERO_TEMP_CORRECTION_FACTOR
        |=> reg_rvalid && reg_rdata == $past(temp_factor_in[31:16]))
    else $error("correction factor upper half misread");

  a_clash_refused:
    assert property (@(posedge clk) disable iff (reset)
      reg_rd && reg_wr |=> reg_err && !reg_rvalid && s_r.units == $past(s_r.units)
        && s_r.pend_hi == $past(s_r.pend_hi))
    else $error("read and write together were not refused");

  a_unmapped_read:
    assert property (@(posedge clk) disable iff (reset)
      reg_rd && !reg_wr && slot == IDX_NONE |=> reg_rvalid && reg_err && reg_rdata == 16'h0000)
    else $error("unmapped read not flagged");

  a_status_write:
    assert property (@(posedge clk) disable iff (reset)
      reg_wr && !reg_rd && slot < IDX_FIRST_UNIT |=> reg_err && s_r.units == $past(s_r.units))
    else $error("write to a read-only register not refused");

  a_units_hold:
    assert property (@(posedge clk) disable iff (reset)
      !unit_commit |=> s_r.units == $past(s_r.units))
    else $error("unit selection changed without a commit");

  a_rdata_hold:
    assert property (@(posedge clk) disable iff (reset)
      !(reg_rd && !reg_wr) |=> $stable(reg_rdata) && !reg_rvalid)
    else $error("read data changed without a read");

  a_zero_hold:
    assert property (@(posedge clk) disable iff (reset)
      s_r.st != ZS_FINISH |=> $stable(zero_offset))
    else $error("zero point changed outside a zeroing finish");

  a_prior_hold:
    assert property (@(posedge clk) disable iff (reset)
      s_r.st != ZS_FINISH |=> $stable(s_r.prev_zero))
    else $error("previous zero point changed outside a zeroing finish");

  a_interim_hold:
    assert property (@(posedge clk) disable iff (reset)
      !(s_r.st == ZS_RUN && sample_tick) |=> $stable(s_r.interim))
    else $error("interim phase changed without a sample");

  a_progress_hold:
    assert property (@(posedge clk) disable iff (reset)
      s_r.st == ZS_RUN && !sample_tick |=> $stable(s_r.progress) && s_r.st == ZS_RUN)
    else $error("progress count moved without a sample");

  a_final_pulse:
    assert property (@(posedge clk) disable iff (reset)
      final_phase_load |=> !final_phase_load && $stable(final_phase))
    else $error("final phase load held longer than one cycle");

endmodule

// *** bench/phase_source.sv ***
/*
  Model of the sensor front end that feeds zeroing samples to the register bank.
  Assumes the bench pulses go with a sample count and a spacing; samples
  carry phase codes that step up from PH_BASE across the whole run.
*/
`timescale 1ns/100ps

module phase_source #(
  parameter logic [31:0] PH_BASE = 32'h4100_0000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [10:0] n,
  input wire logic [3:0] gap,
  output logic sample_tick,
  output logic [31:0] phase_in
);
  logic [10:0] left;
  logic [3:0] wait_c;
  logic [31:0] k;

  // ----------------------------------------------------------------------------
  // Sample pacing, driven off the falling edge
  // ----------------------------------------------------------------------------
  always @(negedge clk) begin
    if (reset) begin
      left <= 11'h0;
      wait_c <= 4'h0;
      k <= 32'h0;
      sample_tick <= 1'b0;
      phase_in <= 32'h0;
    end else begin
      sample_tick <= 1'b0;
      // Phase is only valid with the tick; garble it in between
      phase_in <= ~phase_in;
      if (go) begin
        left <= n;
        wait_c <= 4'h0;
      end else if (left != 11'h0) begin
        if (wait_c == 4'h0) begin
          sample_tick <= 1'b1;
          phase_in <= PH_BASE + k;
          k <= k + 32'h1;
          left <= left - 11'h1;
          wait_c <= gap - 4'h1;
        end else begin
          wait_c <= wait_c - 4'h1;
        end
      end
    end
  end
endmodule

// *** bench/tb_zeroing_status_and_unit_select_regs.sv ***
/*
  Self-checking bench for the zeroing status and unit selection bank.
  Assumes the phase_source model stands in for the sensor front end and
  the bench itself plays the field master through single-cycle strobes.
*/
`timescale 1ns/100ps

module tb_zeroing_status_and_unit_select_regs;
  import zeroing_unit_pkg::*;
  localparam logic [31:0] PH = 32'h4100_0000;
  logic clk = 1'b1, reset = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, zero_start = 1'b0, go = 1'b0;
  logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata;
  logic reg_rvalid, reg_err, sample_tick, zeroing_busy, final_phase_load;
  logic [31:0] temp_factor_in = 32'h3f80_1234, phase_in, zero_offset, final_phase;
  logic [10:0] sample_total = 11'h1, src_n = 11'h0;
  logic [3:0] src_gap = 4'h1;
  logic [31:0] u_port [4];
  logic [31:0] exp_u [4];
  logic [31:0] ticks = 32'h0, last_zero = 32'h0;
  int n_mismatch = 0, checks_done = 0;

  always #12.5 clk = ~clk;

  zeroing_status_and_unit_select_regs DUT (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
    .temp_factor_in(temp_factor_in), .zeroing_sample_total(sample_total), .zero_start(zero_start),
    .sample_tick(sample_tick), .phase_in(phase_in), .zeroing_busy(zeroing_busy),
    .zero_offset(zero_offset), .final_phase(final_phase), .final_phase_load(final_phase_load),
    .temp_unit_select(u_port[0]), .press_unit_select(u_port[1]),
    .weight_unit_select(u_port[2]), .weight_rate_unit_select(u_port[3]));

  phase_source #(.PH_BASE(PH)) src (.clk(clk), .reset(reset), .go(go), .n(src_n), .gap(src_gap),
    .sample_tick(sample_tick), .phase_in(phase_in));

  // ----------------------------------------------------------------------------
  // Comparison, access tasks and closing
  // ----------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q,
                     output logic e);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_rd = ~wr;
    reg_wr = wr;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    q = reg_rdata;
    // A read without its answer strobe counts as a refusal
    e = reg_err | (~wr & ~reg_rvalid);
  endtask

  task automatic rd32(input logic [15:0] a, input logic [31:0] x, input string nm);
    logic [15:0] hi, lo;
    logic e1, e2;
    acc(1'b0, a, 16'h0, hi, e1);
    acc(1'b0, a + 16'h1, 16'h0, lo, e2);
    chk(nm, {1'b0, x}, {e1 | e2, hi, lo});
  endtask

  task automatic wr32(input logic [15:0] a, input logic [31:0] x, input logic xe);
    logic [15:0] q;
    logic e1, e2;
    acc(1'b1, a, x[31:16], q, e1);
    acc(1'b1, a + 16'h1, x[15:0], q, e2);
    chk("write refusal", {32'h0, xe}, {32'h0, e1 | e2});
  endtask

  function automatic bit legal(int r, int c);
    case (r)
      0: return c >= 1000 && c <= 1003;
      1: return c inside {1130, 1133, 1136, 1137, 1138, 1139, 1141};
      2: return c inside {[1088:1090], [1092:1095], 40001};
      default: return c inside {[1318:1337], [42000:42002]};
    endcase
  endfunction

  task automatic sweep(input int r, input int lo, input int hi);
    for (int c = lo; c <= hi; c++) begin
      wr32(16'h6100 + 16'(2 * r), 32'(c), ~legal(r, c));
      if (legal(r, c)) exp_u[r] = 32'(c);
      rd32(16'h6100 + 16'(2 * r), exp_u[r], "unit readback");
      chk("unit port", {1'b0, exp_u[r]}, {1'b0, u_port[r]});
    end
  endtask

  task automatic defaults;
    exp_u = '{32'h3e9, 32'h470, 32'h440, 32'h52b};
    for (int r = 0; r < 4; r++) rd32(16'h6100 + 16'(2 * r), exp_u[r], "unit default");
  endtask

  task automatic zrun(input logic [10:0] n, input logic [10:0] seed, input logic [3:0] g);
    logic [31:0] fin;
    fin = PH + ticks + 32'(seed) - 32'h1;
    @(negedge clk) zero_start = 1'b1;
    sample_total = n;
    @(negedge clk) zero_start = 1'b0;
    // A second start while busy must not reload the count
    @(negedge clk) zero_start = 1'b1;
    sample_total = 11'h5;
    @(negedge clk) zero_start = 1'b0;
    rd32(16'h4706, 32'(seed), "progress seed");
    chk("busy", 33'h1, {32'h0, zeroing_busy});
    src_n = seed;
    src_gap = g;
    // The model samples go on the same falling edge, so it must not race it
    @(negedge clk) go <= 1'b1;
    @(negedge clk) go <= 1'b0;
    if (g > 4'h4) begin
      @(posedge clk);
      while (sample_tick !== 1'b1) @(posedge clk);
      rd32(16'h4704, PH + ticks, "interim phase");
      rd32(16'h4706, 32'(seed) - 32'h1, "progress step");
    end
    for (int i = 0; i < 2000 && final_phase_load !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("final load", 33'h1, {32'h0, final_phase_load});
    chk("final phase", {1'b0, fin}, {1'b0, final_phase});
    chk("zero offset", {1'b0, fin}, {1'b0, zero_offset});
    rd32(16'h4702, fin, "zero offset reg");
    rd32(16'h4708, last_zero, "previous zero");
    rd32(16'h4706, 32'h0, "progress done");
    chk("busy", 33'h0, {32'h0, zeroing_busy});
    last_zero = fin;
    ticks = ticks + 32'(seed);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [15:0] q;
    logic e;
    repeat (9) @(negedge clk);
    reset = 1'b0;
    defaults();
    rd32(16'h4706, 32'h0, "progress idle");
    rd32(16'h4700, 32'h3f80_1234, "temp factor");
    temp_factor_in = 32'hc2a0_8001;
    rd32(16'h4700, 32'hc2a0_8001, "temp factor live");
    acc(1'b1, 16'h4700, 16'h1, q, e);
    chk("read-only write", 33'h1, {32'h0, e});
    acc(1'b1, 16'h4709, 16'h1, q, e);
    chk("read-only write", 33'h1, {32'h0, e});
    acc(1'b0, 16'h6108, 16'h0, q, e);
    chk("unmapped read", 33'h1_0000, {16'h0, e, q});
    acc(1'b0, 16'h470a, 16'h0, q, e);
    chk("unmapped read", 33'h1_0000, {16'h0, e, q});
    // A read and a write in one cycle must leave the selection alone
    @(negedge clk);
    reg_addr = 16'h6101;
    reg_wdata = 16'h03e8;
    reg_rd = 1'b1;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    chk("rd wr clash", 33'h2, {31'h0, reg_err, reg_rvalid});
    chk("clash unit", {1'b0, exp_u[0]}, {1'b0, u_port[0]});
    sweep(0, 998, 1004);
    sweep(1, 1129, 1142);
    sweep(2, 1087, 1096);
    sweep(2, 39999, 40002);
    sweep(3, 1316, 1339);
    sweep(3, 41999, 42003);
    zrun(11'h3, 11'h3, 4'h1);
    zrun(11'h2, 11'h2, 4'hf);
    zrun(11'h0, 11'h1f4, 4'h1);
    zrun(11'h400, 11'h400, 4'h1);
    @(negedge clk) reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    defaults();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule
